// [logic/rsc_top.sv]
`timescale 1ns/1ps

// Function
// - At start-up, detect buck or buck-boost topology from the low-side gate pin.
// - Pre-regulator is enabled after reset without any host command.
// - Core regulator switchable by host command; enabled after reset.
// - Core overvoltage disables the core regulator.
// - Core and analog-reference diagnostics are latched in status and raise interrupts.
// - Analog-reference regulator switchable by host command; enabled after reset.
// - Analog-reference overvoltage disables it; overcurrent only with external pass transistor.
// - Auxiliary regulator switchable by host command; enabled after reset.
// - Auxiliary overcurrent or overvoltage disables it, is recorded, raises interrupt.
// - Auxiliary regulator can be set to track the analog-reference output.
// - Selection resistor band decodes to one of four 3.3/5.0 V voltage pairs.
// - Selection is sampled after every power-on reset and every low-power-off wake-up.
// - Sampled voltage configuration stays latched until the next sampling.
// - Latched voltage configuration is readable by the host.
// - Resistor tied to pre-regulator means auxiliary unused; only analog voltage decoded.
// - Each interrupt condition gives one low pulse on the interrupt output; conditions in one cycle share one pulse, those during pulse and gap share the next.
// - Host sets interrupt behaviour and pulse length during initialisation; device applies it.
// - Long pulse lasts nominally 100 us, never under 90 us.
// - Short pulse lasts nominally 25 us, never under 20 us.
module rsc_top #(
	parameter int unsigned IRQ_LONG_CYCLES = rsc_pkg::IRQ_LONG_CYC,
	parameter int unsigned IRQ_SHORT_CYCLES = rsc_pkg::IRQ_SHORT_CYC
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic low_side_gate_pin,
	input wire logic wake_low_power_off_mode,
	input wire logic [1:0] sel_band,
	input wire logic sel_to_pre,
	input wire rsc_pkg::rsc_fault_t fault_in,
	input wire logic aref_ext_pass,
	input wire logic ctl_wr,
	input wire rsc_pkg::rsc_regctl_t ctl_data,
	input wire logic init_phase,
	input wire logic irq_cfg_wr,
	input wire rsc_pkg::rsc_irqcfg_t irq_cfg_data,
	input wire logic status_rd,
	output rsc_pkg::rsc_enables_t reg_enables,
	output logic aux_track,
	output logic buck_boost_mode,
	output logic cfg_valid,
	output rsc_pkg::rsc_vcfg_t vcfg_readback,
	output rsc_pkg::rsc_fault_t fault_status,
	output rsc_pkg::rsc_irqcfg_t irq_cfg,
	output logic irq_pulse_n
);

	// ==========================================================
	// Decoding of the selection resistor band.
	function automatic rsc_pkg::rsc_vcfg_t decode_sel(input logic [1:0] band,
			input logic to_pre);
		rsc_pkg::rsc_vcfg_t v;
		v.aux_used = !to_pre;
		v.aux_5v = 1'b0;
		v.aref_5v = 1'b0;
		case (band)
			rsc_pkg::SEL_BAND_5K: begin
				v.aref_5v = 1'b0;
				v.aux_5v = 1'b0;
			end
			rsc_pkg::SEL_BAND_12K: begin
				v.aref_5v = 1'b1;
				v.aux_5v = 1'b1;
			end
			rsc_pkg::SEL_BAND_24K: begin
				v.aref_5v = 1'b0;
				v.aux_5v = 1'b1;
			end
			rsc_pkg::SEL_BAND_51K: begin
				v.aref_5v = 1'b1;
				v.aux_5v = 1'b0;
			end
			default: begin
				v.aref_5v = 1'b0;
				v.aux_5v = 1'b0;
			end
		endcase
		if (to_pre) begin
			v.aux_5v = 1'b0;
		end
		return v;
	endfunction : decode_sel

	// ==========================================================
	// Pin synchronisers.
	logic [rsc_pkg::SYNC_W-1:0] pins_raw;
	logic [rsc_pkg::SYNC_W-1:0] pins_sync;
	rsc_pkg::rsc_fault_t fault_s;
	logic gate_s;
	logic wake_s;

	assign pins_raw = {wake_low_power_off_mode, low_side_gate_pin, fault_in};
	assign fault_s = pins_sync[rsc_pkg::FAULT_W-1:0];
	assign gate_s = pins_sync[rsc_pkg::FAULT_W];
	assign wake_s = pins_sync[rsc_pkg::FAULT_W+1];

	rsc_pin_sync #(
		.W(rsc_pkg::SYNC_W)
	) u_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.pin_in(pins_raw),
		.pin_out(pins_sync)
	);

	// Selection band and strap come from the analog front end as well.
	logic [2:0] sel_sync;

	rsc_pin_sync #(
		.W(3)
	) u_sel_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.pin_in({sel_to_pre, sel_band}),
		.pin_out(sel_sync)
	);

	// ==========================================================
	// Start-up and wake-up sampling sequence.
	rsc_pkg::rsc_seq_t seq_r;
	rsc_pkg::rsc_seq_t seq_nxt;
	logic [3:0] settle_r;
	logic wake_prev_r;
	logic wake_rise;
	logic settle_done;
	logic sample_now;

	assign wake_rise = wake_s && !wake_prev_r;
	assign settle_done = settle_r == rsc_pkg::SETTLE_CYC;
	assign sample_now = seq_r == rsc_pkg::RSC_SEQ_SAMPLE;

	always_comb begin
		seq_nxt = seq_r;
		case (seq_r)
			rsc_pkg::RSC_SEQ_SETTLE: begin
				if (settle_done) begin
					seq_nxt = rsc_pkg::RSC_SEQ_SAMPLE;
				end
			end
			rsc_pkg::RSC_SEQ_SAMPLE: begin
				seq_nxt = rsc_pkg::RSC_SEQ_RUN;
			end
			rsc_pkg::RSC_SEQ_RUN: begin
				if (wake_rise) begin
					seq_nxt = rsc_pkg::RSC_SEQ_SETTLE;
				end
			end
			default: begin
				seq_nxt = rsc_pkg::RSC_SEQ_SETTLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			seq_r <= rsc_pkg::RSC_SEQ_SETTLE;
			settle_r <= 4'h0;
			wake_prev_r <= 1'b0;
		end else begin
			seq_r <= seq_nxt;
			wake_prev_r <= wake_s;
			if (seq_r == rsc_pkg::RSC_SEQ_SETTLE && !settle_done) begin
				settle_r <= settle_r + 4'h1;
			end else if (seq_r != rsc_pkg::RSC_SEQ_SETTLE) begin
				settle_r <= 4'h0;
			end
		end
	end

	// ==========================================================
	// Latched topology and voltage configuration.
	rsc_pkg::rsc_vcfg_t vcfg_dec;

	assign vcfg_dec = decode_sel(sel_sync[1:0], sel_sync[2]);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			buck_boost_mode <= 1'b0;
			vcfg_readback <= '0;
			cfg_valid <= 1'b0;
		end else if (sample_now) begin
			buck_boost_mode <= gate_s;
			vcfg_readback <= vcfg_dec;
			cfg_valid <= 1'b1;
		end else if (seq_r == rsc_pkg::RSC_SEQ_SETTLE) begin
			cfg_valid <= 1'b0;
		end
	end

	// ==========================================================
	// Fault edges and sticky status.
	rsc_pkg::rsc_fault_t fault_prev_r;
	rsc_pkg::rsc_fault_t fault_rise;
	rsc_pkg::rsc_fault_t status_nxt;
	rsc_pkg::rsc_fault_t fault_mask;
	logic any_event;

	// Overcurrent on the analog reference counts only with the external pass device.
	always_comb begin
		fault_mask = '1;
		fault_mask.aref_oc = aref_ext_pass;
	end

	assign fault_rise = fault_s & ~fault_prev_r & fault_mask;
	// A new event in the read cycle survives the clear.
	assign status_nxt = (status_rd ? '0 : fault_status) | fault_rise;
	assign any_event = |fault_rise;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			fault_prev_r <= '0;
			fault_status <= '0;
		end else begin
			fault_prev_r <= fault_s;
			fault_status <= status_nxt;
		end
	end

	// ==========================================================
	// Regulator enables.
	logic core_kill;
	logic aref_kill;
	logic aux_kill;
	rsc_pkg::rsc_enables_t en_nxt;

	// A fault wins over an enable command given in the same cycle.
	assign core_kill = fault_s.core_ov;
	assign aref_kill = fault_s.aref_ov || (fault_s.aref_oc && aref_ext_pass);
	assign aux_kill = fault_s.aux_ov || fault_s.aux_oc;

	always_comb begin
		en_nxt = reg_enables;
		en_nxt.pre = 1'b1;
		if (ctl_wr) begin
			en_nxt.core = ctl_data.core_on;
			en_nxt.aref = ctl_data.aref_on;
			en_nxt.aux = ctl_data.aux_on;
		end
		if (core_kill) begin
			en_nxt.core = 1'b0;
		end
		if (aref_kill) begin
			en_nxt.aref = 1'b0;
		end
		if (aux_kill) begin
			en_nxt.aux = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			reg_enables <= '1;
			aux_track <= 1'b0;
		end else begin
			reg_enables <= en_nxt;
			if (ctl_wr) begin
				aux_track <= ctl_data.aux_track;
			end
		end
	end

	// ==========================================================
	// Interrupt configuration, accepted only during initialisation.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			irq_cfg.irq_long <= rsc_pkg::IRQ_LONG_RST;
			irq_cfg.irq_ena <= rsc_pkg::IRQ_ENA_RST;
		end else if (irq_cfg_wr && init_phase) begin
			irq_cfg <= irq_cfg_data;
		end
	end

	// ==========================================================
	// Interrupt pulse generator.
	rsc_pkg::rsc_irq_t irq_r;
	rsc_pkg::rsc_irq_t irq_nxt;
	logic [rsc_pkg::CNT_W-1:0] irq_cnt_r;
	logic [rsc_pkg::CNT_W-1:0] irq_cnt_nxt;
	logic irq_pend_r;
	logic irq_pend_nxt;
	logic [rsc_pkg::CNT_W-1:0] pulse_len;
	logic [rsc_pkg::CNT_W-1:0] gap_len;
	logic cnt_last;

	assign pulse_len = irq_cfg.irq_long ? IRQ_LONG_CYCLES[rsc_pkg::CNT_W-1:0]
		: IRQ_SHORT_CYCLES[rsc_pkg::CNT_W-1:0];
	assign gap_len = rsc_pkg::IRQ_GAP_CYC[rsc_pkg::CNT_W-1:0];
	assign cnt_last = irq_cnt_r == rsc_pkg::CNT_ONE;

	always_comb begin
		irq_nxt = irq_r;
		irq_cnt_nxt = irq_cnt_r;
		irq_pend_nxt = irq_pend_r || (any_event && irq_cfg.irq_ena);
		case (irq_r)
			rsc_pkg::RSC_IRQ_IDLE: begin
				if (irq_pend_nxt) begin
					irq_nxt = rsc_pkg::RSC_IRQ_LOW;
					irq_cnt_nxt = pulse_len;
					irq_pend_nxt = 1'b0;
				end
			end
			rsc_pkg::RSC_IRQ_LOW: begin
				irq_cnt_nxt = irq_cnt_r - rsc_pkg::CNT_ONE;
				if (cnt_last) begin
					irq_nxt = rsc_pkg::RSC_IRQ_GAP;
					irq_cnt_nxt = gap_len;
				end
			end
			rsc_pkg::RSC_IRQ_GAP: begin
				irq_cnt_nxt = irq_cnt_r - rsc_pkg::CNT_ONE;
				if (cnt_last) begin
					irq_nxt = rsc_pkg::RSC_IRQ_IDLE;
				end
			end
			default: begin
				irq_nxt = rsc_pkg::RSC_IRQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			irq_r <= rsc_pkg::RSC_IRQ_IDLE;
			irq_cnt_r <= '0;
			irq_pend_r <= 1'b0;
			irq_pulse_n <= 1'b1;
		end else begin
			irq_r <= irq_nxt;
			irq_cnt_r <= irq_cnt_nxt;
			irq_pend_r <= irq_pend_nxt;
			irq_pulse_n <= irq_nxt != rsc_pkg::RSC_IRQ_LOW;
		end
	end

endmodule : rsc_top

// [logic/rsc_pkg.sv]
package rsc_pkg;

	// ==========================================================
	// Timing.
	localparam int unsigned CLK_MHZ = 250;
	localparam int unsigned IRQ_LONG_US = 100;
	localparam int unsigned IRQ_SHORT_US = 25;
	localparam int unsigned IRQ_GAP_NS = 1000;
	localparam int unsigned CLK_PERIOD_NS = 4;
	localparam int unsigned IRQ_LONG_CYC = IRQ_LONG_US * CLK_MHZ;
	localparam int unsigned IRQ_SHORT_CYC = IRQ_SHORT_US * CLK_MHZ;
	localparam int unsigned IRQ_GAP_CYC = (IRQ_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CNT_W = 16;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

	// Cycles after a power-on reset or a wake-up before the straps are sampled.
	localparam logic [3:0] SETTLE_CYC = 4'h6;

	// ==========================================================
	// Selection resistor bands.
	localparam logic [1:0] SEL_BAND_5K = 2'h0;
	localparam logic [1:0] SEL_BAND_12K = 2'h1;
	localparam logic [1:0] SEL_BAND_24K = 2'h2;
	localparam logic [1:0] SEL_BAND_51K = 2'h3;

	// ==========================================================
	// Reset values and widths.
	localparam logic IRQ_LONG_RST = 1'b1;
	localparam logic IRQ_ENA_RST = 1'b1;
	localparam int unsigned FAULT_W = 8;
	localparam int unsigned SYNC_W = 10;

	// ==========================================================
	// Types.
	typedef struct packed {
		logic aux_oc;
		logic aux_ov;
		logic aux_uv;
		logic aref_oc;
		logic aref_ov;
		logic aref_uv;
		logic core_ov;
		logic core_uv;
	} rsc_fault_t;

	typedef struct packed {
		logic aux_track;
		logic aux_on;
		logic aref_on;
		logic core_on;
	} rsc_regctl_t;

	typedef struct packed {
		logic aux_used;
		logic aux_5v;
		logic aref_5v;
	} rsc_vcfg_t;

	typedef struct packed {
		logic irq_ena;
		logic irq_long;
	} rsc_irqcfg_t;

	typedef struct packed {
		logic aux;
		logic aref;
		logic core;
		logic pre;
	} rsc_enables_t;

	typedef enum logic [1:0] {
		RSC_SEQ_SETTLE,
		RSC_SEQ_SAMPLE,
		RSC_SEQ_RUN
	} rsc_seq_t;

	typedef enum logic [1:0] {
		RSC_IRQ_IDLE,
		RSC_IRQ_LOW,
		RSC_IRQ_GAP
	} rsc_irq_t;

endpackage : rsc_pkg

// [logic/rsc_pin_sync.sv]
`timescale 1ns/1ps

// Three-stage synchroniser; the output follows once stages two and three agree.
module rsc_pin_sync #(
	parameter int unsigned W = 1
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] pin_out
);

	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			wire agree = s2_r[i] == s3_r[i];
			always_ff @(posedge clk_sys) begin
				if (rst) begin
					s1_r[i] <= 1'b0;
					s2_r[i] <= 1'b0;
					s3_r[i] <= 1'b0;
					pin_out[i] <= 1'b0;
				end else begin
					s1_r[i] <= pin_in[i];
					s2_r[i] <= s1_r[i];
					s3_r[i] <= s2_r[i];
					if (agree) begin
						pin_out[i] <= s3_r[i];
					end
				end
			end
		end
	endgenerate

endmodule : rsc_pin_sync

// [bench/rsc_top_properties.sv]
`timescale 1ns/1ps

module rsc_top_properties #(
	parameter int unsigned IRQ_LONG_CYCLES = 40,
	parameter int unsigned IRQ_SHORT_CYCLES = 10
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ctl_wr,
	input wire rsc_pkg::rsc_regctl_t ctl_data,
	input wire logic init_phase,
	input wire logic irq_cfg_wr,
	input wire rsc_pkg::rsc_irqcfg_t irq_cfg_data,
	input wire logic status_rd,
	input wire rsc_pkg::rsc_enables_t reg_enables,
	input wire logic aux_track,
	input wire logic cfg_valid,
	input wire rsc_pkg::rsc_vcfg_t vcfg_readback,
	input wire rsc_pkg::rsc_fault_t fault_status,
	input wire rsc_pkg::rsc_irqcfg_t irq_cfg,
	input wire logic irq_pulse_n
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Counts the cycles for which the interrupt line has been low.
	int low_cnt_r;
	always_ff @(posedge clk_sys) begin
		if (rst || irq_pulse_n) begin
			low_cnt_r <= 0;
		end else begin
			low_cnt_r <= low_cnt_r + 1;
		end
	end
	pre_always_on_a: assert property (reg_enables.pre)
		else $error("pre-regulator off");
	core_cmd_off_a: assert property (ctl_wr && !ctl_data.core_on |=> !reg_enables.core)
		else $error("core off command ignored");
	aux_track_cmd_a: assert property (ctl_wr |=> aux_track == $past(ctl_data.aux_track))
		else $error("tracking mode not applied");
	core_ov_off_a: assert property ($rose(fault_status.core_ov) |-> !reg_enables.core)
		else $error("core stays on after overvoltage");
	aref_ov_off_a: assert property ($rose(fault_status.aref_ov) |-> !reg_enables.aref)
		else $error("analog reference stays on after overvoltage");
	aux_fault_off_a: assert property ($rose(fault_status.aux_ov) || $rose(fault_status.aux_oc)
		|-> !reg_enables.aux) else $error("auxiliary stays on after fault");
	irq_on_fault_a: assert property ($rose(fault_status.core_ov) && irq_cfg.irq_ena
		|-> ##[0:400] !irq_pulse_n) else $error("no interrupt pulse");
	irq_width_a: assert property ($rose(irq_pulse_n) |-> low_cnt_r ==
		(irq_cfg.irq_long ? IRQ_LONG_CYCLES : IRQ_SHORT_CYCLES)) else $error("bad pulse width");
	irq_cfg_lock_a: assert property (irq_cfg_wr && !init_phase |=> $stable(irq_cfg))
		else $error("config taken outside init");
	irq_cfg_take_a: assert property (irq_cfg_wr && init_phase |=> irq_cfg == $past(irq_cfg_data))
		else $error("config not taken");
	vcfg_hold_a: assert property (cfg_valid && $past(cfg_valid) |-> $stable(vcfg_readback))
		else $error("voltage config changed");
	status_sticky_a: assert property (1'b1 |=>
		(fault_status & $past(fault_status)) == $past(fault_status) || $past(status_rd))
		else $error("status bit lost");
	cover property ($rose(irq_pulse_n) && irq_cfg.irq_long);
	cover property ($rose(irq_pulse_n) && !irq_cfg.irq_long);
	cover property ($rose(cfg_valid));
endmodule : rsc_top_properties

bind rsc_top rsc_top_properties #(
	.IRQ_LONG_CYCLES(IRQ_LONG_CYCLES),
	.IRQ_SHORT_CYCLES(IRQ_SHORT_CYCLES)
) rsc_top_properties_inst (.clk_sys(clk_sys), .rst(rst), .ctl_wr(ctl_wr), .ctl_data(ctl_data),
	.init_phase(init_phase), .irq_cfg_wr(irq_cfg_wr), .irq_cfg_data(irq_cfg_data),
	.status_rd(status_rd), .reg_enables(reg_enables), .aux_track(aux_track),
	.cfg_valid(cfg_valid),
	.vcfg_readback(vcfg_readback), .fault_status(fault_status), .irq_cfg(irq_cfg),
	.irq_pulse_n(irq_pulse_n));

// [bench/rsc_host_model.sv]
`timescale 1ns/1ps

// Host side of the interrupt line: counts pulses and measures their low time.
module rsc_host_model (
	input wire logic clk_sys,
	input wire logic irq_pulse_n,
	output int pulse_cnt,
	output int last_width
);
	int low_r = 0;
	initial begin
		pulse_cnt = 0;
		last_width = 0;
	end
	always @(posedge clk_sys) begin
		if (irq_pulse_n === 1'b0) begin
			low_r <= low_r + 1;
		end else if (low_r != 0) begin
			pulse_cnt <= pulse_cnt + 1;
			last_width <= low_r;
			low_r <= 0;
		end
	end
endmodule : rsc_host_model

// [bench/test_regulator_supervision_control.sv]
`timescale 1ns/1ps

module test_regulator_supervision_control;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic gate = 1'b0;
	logic wake = 1'b0;
	logic [1:0] band = 2'h0;
	logic to_pre = 1'b0;
	logic [7:0] flt = 8'h00;
	logic ext = 1'b0;
	logic ctl_wr = 1'b0;
	logic [3:0] ctl = 4'h0;
	logic init = 1'b0;
	logic cfg_wr = 1'b0;
	logic [1:0] cfg = 2'h0;
	logic rd = 1'b0;
	logic [3:0] en;
	logic trk, bb, valid, irq_n;
	logic [2:0] vcfg;
	logic [7:0] st;
	logic [1:0] icfg;
	int pulses, width, mismatches = 0, checks_done = 0;
	logic [31:0] lfsr = 32'h000175bf;
	int fbit[7] = '{1, 3, 4, 4, 6, 7, 0};
	logic [3:0] fen[7] = '{4'hd, 4'hb, 4'hb, 4'hf, 4'h7, 4'h7, 4'hf};

	always #2 clk_sys = ~clk_sys;

	rsc_top #(.IRQ_LONG_CYCLES(40), .IRQ_SHORT_CYCLES(10)) rsc_top_inst (.clk_sys(clk_sys),
		.rst(rst), .low_side_gate_pin(gate), .wake_low_power_off_mode(wake), .sel_band(band),
		.sel_to_pre(to_pre), .fault_in(flt), .aref_ext_pass(ext), .ctl_wr(ctl_wr),
		.ctl_data(ctl), .init_phase(init), .irq_cfg_wr(cfg_wr), .irq_cfg_data(cfg),
		.status_rd(rd), .reg_enables(en), .aux_track(trk), .buck_boost_mode(bb),
		.cfg_valid(valid), .vcfg_readback(vcfg), .fault_status(st), .irq_cfg(icfg),
		.irq_pulse_n(irq_n));
	rsc_host_model rsc_host_model_inst (.clk_sys(clk_sys), .irq_pulse_n(irq_n),
		.pulse_cnt(pulses), .last_width(width));

	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction : rnd

	function automatic logic [2:0] vcfg_model(int b, int p);
		if (p != 0) return {2'b00, b[0]};
		return {1'b1, (b == 1 || b == 2), b[0]};
	endfunction : vcfg_model

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic end_sim();
		if (mismatches == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : end_sim

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : cyc

	task automatic strobe(ref logic s);
		@(negedge clk_sys) s = 1'b1;
		@(negedge clk_sys) s = 1'b0;
	endtask : strobe

	initial begin
		repeat (30000) @(posedge clk_sys);
		mismatches++;
		end_sim();
	end

	initial begin
		logic [31:0] c;
		int n;
		logic ign;
		logic pul;
		int exp_w[$];
		for (int i = 0; i < 4; i++) begin
			c = rnd();
			band = c[1:0];
			to_pre = c[2];
			gate = c[3];
			if (i == 0) begin
				rst = 1'b1;
				cyc(12);
				rst = 1'b0;
				check(en, 4'hf);
				check(icfg, 2'h3);
			end else begin
				wake = 1'b1;
				cyc(8);
				wake = 1'b0;
			end
			check(valid, 1'b0);
			for (int k = 0; k < 40 && valid !== 1'b1; k++) cyc(1);
			check(valid, 1'b1);
			check(vcfg, vcfg_model(c[1:0], c[2]));
			check(bb, c[3]);
			band = ~band;
			cyc(20);
			check(vcfg, vcfg_model(c[1:0], c[2]));
		end
		for (int i = 0; i < 4; i++) begin
			c = rnd();
			// Core, analog-reference and auxiliary regulators may each be switched off; the pre-regulator stays on.
			ctl = c[3:0];
			strobe(ctl_wr);
			check(en, {c[2:0], 1'b1});
			check(trk, c[3]);
		end
		ctl = 4'h7;
		strobe(ctl_wr);
		for (int j = 0; j < 7; j++) begin
			init = 1'b1;
			cfg = {j != 6, j[0]};
			strobe(cfg_wr);
			init = 1'b0;
			cfg = 2'h0;
			strobe(cfg_wr);
			check(icfg, {j != 6, j[0]});
			ext = (j == 2);
			ign = (fbit[j] == 4) && !ext;
			pul = !ign && j != 6;
			if (pul) exp_w.push_back(j[0] ? 40 : 10);
			n = pulses;
			flt[fbit[j]] = 1'b1;
			cyc(10);
			check(en, fen[j]);
			check(st[fbit[j]], !ign);
			flt = 8'h00;
			cyc(400);
			check(pulses, n + pul);
			if (pul) check(width, exp_w.pop_front());
			check(en, fen[j]);
			strobe(rd);
			check(st, 8'h00);
			strobe(ctl_wr);
			check(en, 4'hf);
		end
		end_sim();
	end
endmodule : test_regulator_supervision_control
